// file: common/sasop_defs.svh
// register map, data positions and counts for the serial audio output port
// Contract
// RULE1 - samples go out two's-complement, msb first
// RULE2 - left word always precedes right word
// RULE3 - read edge select picks transmit clock edge
// RULE4 - master mode drives all three clocks
// RULE5 - master frame is 64 bits, two fields
// RULE6 - slave word clock driven except position mode
// RULE7 - host derives slave clocks from one source
// RULE8 - gated or continuous slave bit clock works
// RULE9 - any idle bit clocks before channel change
// RULE10 - slave right-justified msb on cycle 17
// RULE11 - word clock input sampled, msb follows next
// RULE12 - slave left-justified msb on first edge
// RULE13 - slave i2s word clock rises second cycle
// RULE14 - master right-justified framing from cycle 17
// RULE15 - master plus-one pulses word clock once
// RULE16 - master left-justified msb at field start
// RULE17 - master i2s msb delayed one cycle
// RULE18 - slave idle until low-then-high channel clock
// RULE19 - two level flag bits per sample, msb first
// RULE20 - words update in last eighth of frame
`ifndef SASOP_DEFS_SVH
`define SASOP_DEFS_SVH
`define SASOP_WORD_W 16
`define SASOP_TAG_W 2
`define SASOP_ADDR_CTRL 4'h0
`define SASOP_ADDR_STAT 4'h4
`define SASOP_CTRL_RST 4'h0
`define SASOP_POS_LJ 5'h00
`define SASOP_POS_I2S 5'h01
`define SASOP_POS_RJ 5'h10
`define SASOP_POS_RJ1 5'h11
`define SASOP_WORD_SPAN 5'h0F
`define SASOP_CNT_LAST 5'h1F
`define SASOP_CNT_UPD 5'h18
`define SASOP_CNT_TAG0 5'h00
`define SASOP_CNT_TAG1 5'h01
`define SASOP_WCLK_PULSE 5'h10
`define SASOP_BITS_LAST 4'hF
`define SASOP_FRAME_RST 6'h3F
`endif

// file: common/sasop_pkg.sv
// types shared by the serial audio output port
`default_nettype none
`include "sasop_defs.svh"
package sasop_pkg;
  typedef struct packed {
    logic read_edge;
    logic msb_delay_n;
    logic justify;
    logic slave;
  } sasop_ctrl_s;
  typedef struct packed {
    logic [`SASOP_TAG_W-1:0] tag_left;
    logic [`SASOP_TAG_W-1:0] tag_right;
    logic [`SASOP_WORD_W-1:0] left;
    logic [`SASOP_WORD_W-1:0] right;
  } sasop_sample_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_RUN = 3'b100
  } sasop_state_e;
endpackage
`default_nettype wire

// file: hw/sasop_port.sv
// serial audio output port: framing, clocks, shifter and register slave
//
// The register addresses and the strobed register port were decided locally.
`default_nettype none
`include "sasop_defs.svh"
module sasop_port import sasop_pkg::*; #(
  parameter int BCLK_HALF = 2
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [3:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire sasop_sample_s sample_in,
  input wire logic sample_valid,
  input wire logic bit_clock_in,
  output logic bit_clock_out,
  output logic bit_clock_oe_n,
  input wire logic channel_select_clock_in,
  output logic channel_select_clock_out,
  output logic channel_select_clock_oe_n,
  input wire logic word_clock_in,
  output logic word_clock_out,
  output logic word_clock_oe_n,
  output logic serial_data_out,
  output logic level_flag_out
);
  localparam int DIV_W = $clog2(BCLK_HALF) + 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BCLK_HALF - 1);

  // first data cycle of a field for the selected mode
  function automatic logic [4:0] start_pos(input sasop_ctrl_s c);
    if (c.justify) begin
      if (c.msb_delay_n || c.slave) begin
        start_pos = `SASOP_POS_RJ;
      end else begin
        start_pos = `SASOP_POS_RJ1;
      end
    end else if (c.msb_delay_n) begin
      start_pos = `SASOP_POS_LJ;
    end else begin
      start_pos = `SASOP_POS_I2S;
    end
  endfunction

  sasop_ctrl_s ctrl, next_ctrl;
  sasop_state_e state, next_state;
  sasop_sample_s pend, next_pend;
  sasop_sample_s cur, next_cur;
  logic [DIV_W-1:0] div, next_div;
  logic [5:0] frame, next_frame;
  logic [4:0] cnt, next_cnt;
  logic [`SASOP_WORD_W-1:0] shreg, next_shreg;
  logic [3:0] bits_left, next_bits_left;
  logic field_channel_select_clock, next_field_channel_select_clock;
  logic started, next_started;
  logic wclk_seen, next_wclk_seen;
  logic bclk_q, channel_select_clock_q;
  logic [31:0] next_rdata;
  logic next_bclk_out;
  logic next_bclk_oe_n;
  logic next_channel_select_clock_out;
  logic next_channel_select_clock_oe_n;
  logic next_wclk_out;
  logic next_wclk_oe_n;
  logic next_sdo;
  logic next_tag;
  logic tx_lvl;
  logic tx_ev, smp_ev;
  logic wclk_in_mode;
  logic new_field;
  logic started_eff, seen_eff;
  logic start_now;
  logic channel_select_clock_n;
  logic [4:0] cnt_n;
  logic [4:0] pos;
  logic [`SASOP_WORD_W-1:0] word;
  logic [`SASOP_TAG_W-1:0] tag;
  logic ctrl_wr;

  always_comb begin
    next_ctrl = ctrl;
    next_state = state;
    next_pend = pend;
    next_cur = cur;
    next_div = div;
    next_frame = frame;
    next_cnt = cnt;
    next_shreg = shreg;
    next_bits_left = bits_left;
    next_field_channel_select_clock = field_channel_select_clock;
    next_started = started;
    next_wclk_seen = wclk_seen;
    next_bclk_out = bit_clock_out;
    next_channel_select_clock_out = channel_select_clock_out;
    next_wclk_out = word_clock_out;
    next_sdo = serial_data_out;
    next_tag = level_flag_out;
    next_rdata = '0;
    tx_lvl = ~ctrl.read_edge;
    wclk_in_mode = ctrl.slave & ctrl.justify & ~ctrl.msb_delay_n;
    pos = start_pos(ctrl);
    tx_ev = 1'b0;
    smp_ev = 1'b0;
    new_field = 1'b0;
    started_eff = started;
    seen_eff = wclk_seen;
    start_now = 1'b0;
    cnt_n = cnt;
    channel_select_clock_n = field_channel_select_clock;
    word = '0;
    tag = '0;
    ctrl_wr = bus_wr && (bus_addr == `SASOP_ADDR_CTRL);
    // RULE4 RULE6 pin directions
    next_bclk_oe_n = ctrl.slave;
    next_channel_select_clock_oe_n = ctrl.slave;
    next_wclk_oe_n = wclk_in_mode;

    if (bus_rd) begin
      case (bus_addr)
        `SASOP_ADDR_CTRL: next_rdata = {28'h0000000, ctrl};
        `SASOP_ADDR_STAT: next_rdata = {24'h000000, state == ST_RUN, field_channel_select_clock, 1'b0, cnt};
        default: next_rdata = '0;
      endcase
    end
    if (sample_valid) begin
      next_pend = sample_in;
    end

    // RULE3 RULE8 transmit and sample edges
    if (ctrl.slave) begin
      tx_ev = (bclk_q != bit_clock_in) && (bit_clock_in == tx_lvl);
      smp_ev = (bclk_q != bit_clock_in) && (bit_clock_in != tx_lvl);
    end else if (div == DIV_LAST) begin
      next_div = '0;
      next_bclk_out = ~bit_clock_out;
      tx_ev = (~bit_clock_out == tx_lvl);
      smp_ev = ~tx_ev;
    end else begin
      next_div = div + 1'b1;
    end

    // RULE18 slave start-up arming
    case (state)
      ST_IDLE: begin
        if (!ctrl.slave) begin
          next_state = ST_RUN;
        end else if (channel_select_clock_oe_n && channel_select_clock_q && !channel_select_clock_in) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!channel_select_clock_q && channel_select_clock_in) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_IDLE;
    endcase

    if (state == ST_RUN && tx_ev) begin
      if (ctrl.slave) begin
        if (channel_select_clock_in != field_channel_select_clock) begin
          new_field = 1'b1;
          cnt_n = '0;
          channel_select_clock_n = channel_select_clock_in;
        end else if (cnt != `SASOP_CNT_LAST) begin
          // RULE9 count saturates over idle clocks
          cnt_n = cnt + 1'b1;
        end
      end else begin
        // RULE5 64-bit frame, high then low field
        next_frame = frame + 1'b1;
        cnt_n = next_frame[4:0];
        channel_select_clock_n = ~next_frame[5];
        new_field = (cnt_n == '0);
      end
      next_cnt = cnt_n;
      next_field_channel_select_clock = channel_select_clock_n;
      next_channel_select_clock_out = channel_select_clock_n;
      started_eff = started & ~new_field;
      seen_eff = wclk_seen & ~new_field;
      next_started = started_eff;
      next_wclk_seen = seen_eff;
      // RULE2 high field carries left word
      word = channel_select_clock_n ? cur.left : cur.right;
      tag = channel_select_clock_n ? cur.tag_left : cur.tag_right;
      // RULE10 RULE11 RULE12 RULE16 RULE17 start point
      if (wclk_in_mode) begin
        start_now = seen_eff & ~started_eff;
      end else begin
        start_now = (cnt_n == pos) & ~started_eff;
      end
      // RULE1 msb first shifter
      if (start_now) begin
        next_sdo = word[`SASOP_WORD_W-1];
        next_shreg = {word[`SASOP_WORD_W-2:0], 1'b0};
        next_bits_left = `SASOP_BITS_LAST;
        next_started = 1'b1;
      end else if (bits_left != '0) begin
        next_sdo = shreg[`SASOP_WORD_W-1];
        next_shreg = {shreg[`SASOP_WORD_W-2:0], 1'b0};
        next_bits_left = bits_left - 1'b1;
      end else begin
        next_sdo = 1'b0;
      end
      // RULE14 RULE15 RULE13 word clock framing
      if (!ctrl.slave && ctrl.justify && !ctrl.msb_delay_n) begin
        next_wclk_out = (cnt_n == `SASOP_WCLK_PULSE);
      end else begin
        next_wclk_out = (cnt_n >= pos) && (cnt_n <= pos + `SASOP_WORD_SPAN);
      end
      // RULE19 level flag bits, msb first
      if (cnt_n == `SASOP_CNT_TAG0) begin
        next_tag = tag[1];
      end else if (cnt_n == `SASOP_CNT_TAG1) begin
        next_tag = tag[0];
      end else begin
        next_tag = 1'b0;
      end
      // RULE20 reload only in last eighth
      if (!channel_select_clock_n && cnt_n == `SASOP_CNT_UPD) begin
        next_cur = pend;
      end
    end

    // RULE11 word clock input on sampling edge
    if (state == ST_RUN && smp_ev && wclk_in_mode && word_clock_in && !started) begin
      next_wclk_seen = 1'b1;
    end

    // a mode change restarts framing and drops the word in the shifter; cur keeps its words for the first frame of the new format
    if (ctrl_wr) begin
      next_ctrl = bus_wdata[3:0];
      next_state = ST_IDLE;
      next_frame = `SASOP_FRAME_RST;
      next_cnt = '0;
      next_bits_left = '0;
      next_field_channel_select_clock = 1'b0;
      next_channel_select_clock_out = 1'b0;
      next_started = 1'b0;
      next_wclk_seen = 1'b0;
      next_sdo = 1'b0;
      next_tag = 1'b0;
      next_wclk_out = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl <= `SASOP_CTRL_RST;
      state <= ST_IDLE;
      pend <= '0;
      cur <= '0;
      div <= '0;
      frame <= `SASOP_FRAME_RST;
      cnt <= '0;
      shreg <= '0;
      bits_left <= '0;
      field_channel_select_clock <= 1'b0;
      started <= 1'b0;
      wclk_seen <= 1'b0;
      bclk_q <= 1'b0;
      channel_select_clock_q <= 1'b0;
      bus_rdata <= '0;
      bit_clock_out <= 1'b0;
      bit_clock_oe_n <= 1'b1;
      channel_select_clock_out <= 1'b0;
      channel_select_clock_oe_n <= 1'b1;
      word_clock_out <= 1'b0;
      word_clock_oe_n <= 1'b1;
      serial_data_out <= 1'b0;
      level_flag_out <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      state <= next_state;
      pend <= next_pend;
      cur <= next_cur;
      div <= next_div;
      frame <= next_frame;
      cnt <= next_cnt;
      shreg <= next_shreg;
      bits_left <= next_bits_left;
      field_channel_select_clock <= next_field_channel_select_clock;
      started <= next_started;
      wclk_seen <= next_wclk_seen;
      bclk_q <= bit_clock_in;
      channel_select_clock_q <= channel_select_clock_in;
      bus_rdata <= next_rdata;
      bit_clock_out <= next_bclk_out;
      bit_clock_oe_n <= next_bclk_oe_n;
      channel_select_clock_out <= next_channel_select_clock_out;
      channel_select_clock_oe_n <= next_channel_select_clock_oe_n;
      word_clock_out <= next_wclk_out;
      word_clock_oe_n <= next_wclk_oe_n;
      serial_data_out <= next_sdo;
      level_flag_out <= next_tag;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_master_oe_drive: assert property ( // RULE4
    !ctrl.slave && $stable(ctrl) && !$past(sys_rst)
      |-> !bit_clock_oe_n && !channel_select_clock_oe_n)
    else $error("master mode clocks not driven");
  a_frame_field_start: assert property ( // RULE5
    $rose(channel_select_clock_out) && !ctrl.slave |-> frame == '0)
    else $error("left field does not open the frame");
  a_data_tx_edge: assert property ( // RULE3
    $changed(serial_data_out) && !ctrl.slave && $stable(ctrl)
      |-> bit_clock_out == ~ctrl.read_edge)
    else $error("data changed on the sampling edge");
  a_idle_static: assert property ( // RULE18
    state != ST_RUN && !ctrl_wr |=> $stable(serial_data_out) && $stable(word_clock_out))
    else $error("outputs moved before start-up");
  a_tag_window: assert property ( // RULE19
    cnt > `SASOP_CNT_TAG1 |-> !level_flag_out)
    else $error("level flag outside its two cycles");
  a_update_window: assert property ( // RULE20
    $changed(cur) && !$past(ctrl_wr) |-> !field_channel_select_clock && cnt == `SASOP_CNT_UPD)
    else $error("output words reloaded outside last eighth");
  a_cnt_saturate: assert property ( // RULE9
    ctrl.slave && !ctrl_wr && cnt == `SASOP_CNT_LAST |=> cnt == `SASOP_CNT_LAST || cnt == '0)
    else $error("field count wrapped without channel change");
  a_rj1_single_pulse: assert property ( // RULE15
    word_clock_out && !ctrl.slave && ctrl.justify && !ctrl.msb_delay_n && $stable(ctrl)
      |-> cnt == `SASOP_WCLK_PULSE)
    else $error("plus-one word clock not a cycle 17 pulse");
  a_wclk_rise_pos: assert property ( // RULE13
    $rose(word_clock_out) && !(ctrl.justify && !ctrl.msb_delay_n) |-> cnt == start_pos(ctrl))
    else $error("word clock rose at wrong bit position");
  a_wclk_in_start: assert property ( // RULE11
    wclk_in_mode && $rose(started) |-> $past(wclk_seen))
    else $error("word started without word clock seen");
endmodule
`default_nettype wire

// file: tb/sasop_host.sv
// host model: slave clock source and serial field capture
`default_nettype none
module sasop_host (
  input wire logic clk_sys,
  input wire logic drive,
  input wire logic gated,
  input wire logic read_edge,
  input wire logic bclk,
  input wire logic channel_select_clock,
  input wire logic sdata,
  input wire logic flag,
  input wire logic wclk,
  output logic bclk_drv = 1'b0,
  output logic channel_select_clock_drv = 1'b1,
  output logic [2:0][31:0] cap_l = '0,
  output logic [2:0][31:0] cap_r = '0,
  output logic [15:0] nf = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] h = 4'h0;
  logic [4:0] n = 5'h00;
  logic pb = 1'b0;
  logic pl = 1'b0;
  logic [2:0][31:0] sh = '0;
  wire logic [2:0] v = {sdata, flag, wclk};
  // clocks from clk_sys, gated pause before each field
  always @(posedge clk_sys) begin
    if (!drive) begin
      bclk_drv <= read_edge;
      channel_select_clock_drv <= 1'b1;
      h <= 4'h0;
      n <= 5'h00;
    end else if (h == ((gated && n == 5'h00 && bclk_drv == read_edge) ? 4'hF : 4'h3)) begin
      h <= 4'h0;
      bclk_drv <= ~bclk_drv;
      if (bclk_drv == read_edge) begin
        n <= n + 5'h01;
        if (n == 5'h00) channel_select_clock_drv <= ~channel_select_clock_drv;
      end
    end else begin
      h <= h + 4'h1;
    end
  end
  // capture on the sampling edge, latch a field at channel change
  always @(posedge clk_sys) begin
    pb <= bclk;
    if (bclk != pb && bclk == read_edge) begin
      pl <= channel_select_clock;
      if (channel_select_clock != pl) begin
        nf <= nf + 16'h0001;
        if (pl) cap_l <= sh;
        else cap_r <= sh;
      end
      for (int i = 0; i < 3; i++) begin
        sh[i] <= (channel_select_clock != pl) ? {31'h0, v[i]} : {sh[i][30:0], v[i]};
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// testbench: mode sweep, framing, level flags and register port
`default_nettype none
module tb_top import sasop_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] bus_addr = 4'h0;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  sasop_sample_s sample_in = '0;
  logic sample_valid = 1'b0;
  logic wclk_tb = 1'b1;
  logic drive = 1'b0;
  logic gated = 1'b0;
  logic re = 1'b0;
  logic bco, bcoe, lco, lcoe, wco, wcoe, sdo, flo, bcd, lcd;
  logic [2:0][31:0] cap_l, cap_r;
  logic [15:0] nf;
  int miscompares = 0;
  int check_count = 0;
  wire logic bclk = bcoe ? bcd : bco;
  wire logic channel_select_clock = lcoe ? lcd : lco;
  wire logic wclk = wcoe ? wclk_tb : wco;
  always #50 clk_sys = ~clk_sys;
  sasop_port #(.BCLK_HALF(2)) sasop_port_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .sample_in(sample_in), .sample_valid(sample_valid),
    .bit_clock_in(bclk), .bit_clock_out(bco), .bit_clock_oe_n(bcoe),
    .channel_select_clock_in(channel_select_clock), .channel_select_clock_out(lco),
    .channel_select_clock_oe_n(lcoe), .word_clock_in(wclk), .word_clock_out(wco),
    .word_clock_oe_n(wcoe), .serial_data_out(sdo), .level_flag_out(flo));
  sasop_host sasop_host_i (.clk_sys(clk_sys), .drive(drive), .gated(gated),
    .read_edge(re), .bclk(bclk), .channel_select_clock(channel_select_clock), .sdata(sdo), .flag(flo), .wclk(wclk),
    .bclk_drv(bcd), .channel_select_clock_drv(lcd), .cap_l(cap_l), .cap_r(cap_r), .nf(nf));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    @(posedge clk_sys);
    d = bus_rdata;
  endtask
  task automatic wait_fields(input int k);
    int t;
    t = nf + k;
    for (int i = 0; i < 4000 * k && nf < t; i++) @(posedge clk_sys);
    if (nf < t) begin
      miscompares++;
      $display("CHECK FAILED field count expected %0d seen %0d", t, nf);
      give_verdict();
    end
  endtask
  // expected field: word from cycle s, plus-one spills the other word's lsb into cycle 1
  function automatic logic [31:0] expw(input logic [15:0] w, input logic p, input int s);
    return ({w, 16'h0000} >> (s - 1)) | ((s == 18) ? {p, 31'h0} : 32'h0);
  endfunction
  task automatic test_regs();
    logic [31:0] d;
    bus_read(4'h0, d);
    check("ctrl reset", d, 32'h0);
    bus_write(4'h0, 32'h0000000B);
    bus_write(4'h4, 32'h0000000F);
    bus_read(4'h0, d);
    check("ctrl rw", d, 32'h0000000B);
    bus_read(4'h8, d);
    check("unmapped", d, 32'h0);
  endtask
  task automatic test_mode(input logic [2:0] i);
    logic [31:0] d, wx;
    logic [15:0] lw, rw;
    logic sl, j, m, r;
    int s;
    {sl, j, m} = i;
    r = sl ^ m;
    s = j ? (m ? 17 : (sl ? 2 : 18)) : (m ? 1 : 2);
    lw = 16'hC3A5 ^ {13'h0000, i};
    rw = 16'h5A3C ^ {i, 13'h0000};
    wx = (s == 18) ? 32'h00008000 : ({16'hFFFF, 16'h0000} >> (s - 1));
    drive <= 1'b0;
    gated <= sl & j;
    re <= r;
    sample_in <= {i[1:0], ~i[1:0], lw, rw};
    bus_write(4'h0, {28'h0, r, m, j, sl});
    sample_valid <= 1'b1;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
    if (sl) begin
      repeat (20) @(posedge clk_sys);
      check("idle outputs", {30'h0, wco, sdo}, 32'h0);
      bus_read(4'h4, d);
      check("idle status", {31'h0, d[7]}, 32'h0);
    end
    drive <= sl;
    wait_fields(8);
    check("oe", {29'h0, bcoe, lcoe, wcoe}, {29'h0, sl, sl, sl & j & ~m});
    check("left data", cap_l[2], expw(lw, rw[0], s));
    check("right data", cap_r[2], expw(rw, lw[0], s));
    check("left flag", cap_l[1], {i[1:0], 30'h0});
    check("right flag", cap_r[1], {~i[1:0], 30'h0});
    if (!(sl & j & ~m)) begin
      check("left wclk", cap_l[0], wx);
      check("right wclk", cap_r[0], wx);
    end
    bus_read(4'h4, d);
    check("running", {31'h0, d[7]}, 32'h1);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    test_regs();
    for (int i = 0; i < 8; i++) test_mode(i[2:0]);
    give_verdict();
  end
endmodule
`default_nettype wire
